// *** src/utrb_core.sv ***
// serial transceiver data path: transmit buffer, receive fifo, flags and interrupt requests
`timescale 1ns/1ps
module utrb_core #(
  parameter int BAUD_DIV = utrb_pkg::BAUD_DIV,
  parameter int RX_DEPTH = utrb_pkg::RX_DEPTH
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // configuration and control
  input  wire logic       tx_enable_bit,
  input  wire logic       rx_enable_bit,
  input  wire logic       parity_enable_bit,
  input  wire logic       parity_odd_select,
  input  wire logic       stop_count_select,
  input  wire logic [2:0] char_size_code,
  input  wire logic       sync_mode,
  input  wire logic       tx_empty_irq_en,
  input  wire logic       tx_done_irq_en,
  input  wire logic       rx_avail_irq_en,
  input  wire logic       global_irq_en,
  // software data access
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  input  wire logic       tx_ninth_bit,
  input  wire logic       data_rd,
  output logic [7:0]      data_rdata,
  output logic            rx_ninth_bit,
  input  wire logic       tx_done_clr,
  input  wire logic       tx_done_ack,
  // status
  output logic            tx_buffer_empty_flag,
  output logic            tx_done_flag,
  output logic            rx_avail_flag,
  output logic            stop_bit_error,
  output logic            overrun_flag,
  output logic            parity_fail_flag,
  // interrupt requests
  output logic            tx_empty_irq,
  output logic            tx_done_irq,
  output logic            rx_avail_irq,
  // line pins
  output logic            serial_out_pin,
  output logic            serial_out_oe,
  input  wire logic       serial_in_pin,
  output logic            serial_in_owned,
  input  wire logic       sync_clock_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] bits_of(input logic [2:0] code);
    // reserved codes fall back to eight bits
    if (code == utrb_pkg::CSZ_NINE) begin
      bits_of = utrb_pkg::NBITS_NINE;
    end else if (code > utrb_pkg::CSZ_EIGHT) begin
      bits_of = utrb_pkg::NBITS_EIGHT;
    end else begin
      bits_of = utrb_pkg::NBITS_BASE + {1'b0, code};
    end
  endfunction

  function automatic logic [8:0] mask_of(input logic [3:0] n);
    mask_of = 9'h1ff >> (utrb_pkg::NBITS_NINE - n);
  endfunction

  logic [3:0] nbits;
  logic [8:0] dmask;
  logic       stop_last;

  assign nbits     = bits_of(char_size_code);
  assign dmask     = mask_of(nbits);
  assign stop_last = stop_count_select;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and rate enables

  logic rxd_s1_r;
  logic rxd_s2_r;
  logic rxd_d_r;
  logic xck_s1_r;
  logic xck_s2_r;
  logic xck_d_r;
  logic sync_rise;
  logic os_tick;
  logic tx_en_eff_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      rxd_d_r  <= 1'b1;
      xck_s1_r <= 1'b0;
      xck_s2_r <= 1'b0;
      xck_d_r  <= 1'b0;
    end else begin
      rxd_s1_r <= serial_in_pin;
      rxd_s2_r <= rxd_s1_r;
      rxd_d_r  <= rxd_s2_r;
      xck_s1_r <= sync_clock_pin;
      xck_s2_r <= xck_s1_r;
      xck_d_r  <= xck_s2_r;
    end
  end

  // in synchronous mode the external clock paces both directions
  assign sync_rise = sync_mode & xck_s2_r & ~xck_d_r;

  utrb_baud #(
    .DIV (BAUD_DIV)
  ) u_baud (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .en       (~sync_mode & (tx_en_eff_r | rx_enable_bit)),
    .tick     (os_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer

  utrb_pkg::utrb_tx_state_t tx_state_r;
  logic [8:0] txbuf_r;
  logic       txbuf_full_r;
  logic [8:0] tsh_r;
  logic [3:0] tcnt_r;
  logic [3:0] tx_os_r;
  logic       tpar_r;
  logic       ser_out_r;
  logic       tx_done_r;
  logic       tx_tick;
  logic       tx_stop_end;
  logic       tx_load;
  logic       tx_par_calc;

  assign tx_tick     = sync_mode ? sync_rise : (os_tick && tx_os_r == utrb_pkg::OS_LAST);
  assign tx_stop_end = tx_tick && (tx_state_r == utrb_pkg::TX_STOP) && (tcnt_r[0] == stop_last);
  assign tx_load     = txbuf_full_r && tx_en_eff_r &&
                       ((tx_state_r == utrb_pkg::TX_IDLE) || tx_stop_end);
  assign tx_par_calc = ^(txbuf_r & dmask) ^ parity_odd_select;

  // ninth bit is latched with the low byte, so it must already be in place
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_r      <= '0;
      txbuf_full_r <= 1'b0;
    end else if (data_wr && tx_enable_bit) begin
      txbuf_r      <= {tx_ninth_bit, data_wdata};
      txbuf_full_r <= 1'b1;
    end else if (tx_load) begin
      txbuf_full_r <= 1'b0;
    end
  end

  assign tx_buffer_empty_flag = ~txbuf_full_r;

  ////////////////////////////////////////////////////////////////////////////
  // transmit shift register

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_os_r <= utrb_pkg::OS_ZERO;
    end else if (tx_state_r == utrb_pkg::TX_IDLE) begin
      tx_os_r <= utrb_pkg::OS_ZERO;
    end else if (os_tick) begin
      tx_os_r <= tx_os_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= utrb_pkg::TX_IDLE;
      tsh_r      <= '0;
      tcnt_r     <= '0;
      tpar_r     <= 1'b0;
      ser_out_r  <= 1'b1;
    end else begin
      case (tx_state_r)
        utrb_pkg::TX_IDLE: begin
          ser_out_r <= 1'b1;
          if (tx_load) begin
            tx_state_r <= utrb_pkg::TX_START;
            tsh_r      <= txbuf_r & dmask;
            tpar_r     <= tx_par_calc;
            ser_out_r  <= 1'b0;
          end
        end
        utrb_pkg::TX_START: begin
          if (tx_tick) begin
            tx_state_r <= utrb_pkg::TX_DATA;
            ser_out_r  <= tsh_r[0];
            tsh_r      <= tsh_r >> 1;
            tcnt_r     <= 4'h1;
          end
        end
        utrb_pkg::TX_DATA: begin
          if (tx_tick) begin
            if (tcnt_r == nbits) begin
              tcnt_r <= '0;
              if (parity_enable_bit) begin
                tx_state_r <= utrb_pkg::TX_PAR;
                ser_out_r  <= tpar_r;
              end else begin
                tx_state_r <= utrb_pkg::TX_STOP;
                ser_out_r  <= 1'b1;
              end
            end else begin
              ser_out_r <= tsh_r[0];
              tsh_r     <= tsh_r >> 1;
              tcnt_r    <= tcnt_r + 1'b1;
            end
          end
        end
        utrb_pkg::TX_PAR: begin
          if (tx_tick) begin
            tx_state_r <= utrb_pkg::TX_STOP;
            ser_out_r  <= 1'b1;
          end
        end
        utrb_pkg::TX_STOP: begin
          if (tx_stop_end) begin
            tcnt_r <= '0;
            if (tx_load) begin
              // back-to-back frame starts with no idle gap
              tx_state_r <= utrb_pkg::TX_START;
              tsh_r      <= txbuf_r & dmask;
              tpar_r     <= tx_par_calc;
              ser_out_r  <= 1'b0;
            end else begin
              tx_state_r <= utrb_pkg::TX_IDLE;
            end
          end else if (tx_tick) begin
            tcnt_r <= tcnt_r + 1'b1;
          end
        end
        default: begin
          tx_state_r <= utrb_pkg::TX_IDLE;
          ser_out_r  <= 1'b1;
        end
      endcase
    end
  end

  // done flag: a new completion in the clearing cycle wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_done_r <= 1'b0;
    end else if (tx_stop_end && !txbuf_full_r) begin
      tx_done_r <= 1'b1;
    end else if (tx_done_ack || tx_done_clr) begin
      tx_done_r <= 1'b0;
    end
  end

  // the pin stays with the transmitter until pending data has gone out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_eff_r <= 1'b0;
    end else if (tx_enable_bit) begin
      tx_en_eff_r <= 1'b1;
    end else if (tx_state_r == utrb_pkg::TX_IDLE && !txbuf_full_r) begin
      tx_en_eff_r <= 1'b0;
    end
  end

  assign tx_done_flag   = tx_done_r;
  assign serial_out_pin = ser_out_r;
  assign serial_out_oe  = tx_en_eff_r;

  ////////////////////////////////////////////////////////////////////////////
  // receive shift register

  utrb_pkg::utrb_rx_state_t rx_state_r;
  logic [8:0] rsh_r;
  logic [3:0] rcnt_r;
  logic [3:0] rx_os_r;
  logic       rpar_r;
  logic       rx_smp;
  logic       rx_go;
  logic       start_det;
  logic       frame_done;
  logic       rx_in;
  logic [8:0] rx_aligned;
  logic       rx_fe;
  logic       rx_pe;

  assign rx_in  = rxd_s2_r;
  assign rx_smp = sync_mode ? sync_rise :
                  (os_tick && rx_os_r == ((rx_state_r == utrb_pkg::RX_START) ?
                                          utrb_pkg::OS_MID : utrb_pkg::OS_LAST));
  // in asynchronous mode a falling edge starts a frame, so a low stop bit cannot restart the receiver; in synchronous mode a low line at a clock rise does
  assign rx_go  = (rx_state_r == utrb_pkg::RX_IDLE) && !rx_in && rx_enable_bit &&
                  (sync_mode ? sync_rise : rxd_d_r);
  assign start_det = (sync_mode && rx_go) ||
                     (rx_state_r == utrb_pkg::RX_START && rx_smp && !rx_in);
  assign frame_done = rx_enable_bit && rx_smp && (rx_state_r == utrb_pkg::RX_STOP);

  assign rx_aligned = 9'(rsh_r >> (utrb_pkg::NBITS_NINE - nbits));
  assign rx_fe      = ~rx_in;
  assign rx_pe      = parity_enable_bit &
                      ((^rx_aligned ^ parity_odd_select) != rpar_r);

  // oversample phase restarts on every state change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_os_r <= utrb_pkg::OS_ZERO;
    end else if (rx_go || rx_smp || rx_state_r == utrb_pkg::RX_IDLE) begin
      rx_os_r <= utrb_pkg::OS_ZERO;
    end else if (os_tick) begin
      rx_os_r <= rx_os_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= utrb_pkg::RX_IDLE;
      rsh_r      <= '0;
      rcnt_r     <= '0;
      rpar_r     <= 1'b0;
    end else if (!rx_enable_bit) begin
      rx_state_r <= utrb_pkg::RX_IDLE;
    end else begin
      case (rx_state_r)
        utrb_pkg::RX_IDLE: begin
          rcnt_r <= '0;
          rsh_r  <= '0;
          if (rx_go) begin
            rx_state_r <= sync_mode ? utrb_pkg::RX_DATA : utrb_pkg::RX_START;
          end
        end
        utrb_pkg::RX_START: begin
          // a start that is high at mid bit is noise
          if (rx_smp) begin
            rx_state_r <= rx_in ? utrb_pkg::RX_IDLE : utrb_pkg::RX_DATA;
          end
        end
        utrb_pkg::RX_DATA: begin
          if (rx_smp) begin
            rsh_r  <= {rx_in, rsh_r[8:1]};
            rcnt_r <= rcnt_r + 1'b1;
            if (rcnt_r + 1'b1 == nbits) begin
              rx_state_r <= parity_enable_bit ? utrb_pkg::RX_PAR : utrb_pkg::RX_STOP;
            end
          end
        end
        utrb_pkg::RX_PAR: begin
          if (rx_smp) begin
            rpar_r     <= rx_in;
            rx_state_r <= utrb_pkg::RX_STOP;
          end
        end
        utrb_pkg::RX_STOP: begin
          // only the first stop bit is looked at; a second one is idle line
          if (rx_smp) begin
            rx_state_r <= utrb_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= utrb_pkg::RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waiting character, overrun and receive fifo

  logic [utrb_pkg::HOLD_W-1:0] hold_r;
  logic                        hold_valid_r;
  logic                        dor_pend_r;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic [utrb_pkg::WORD_W-1:0] fifo_out_data;
  logic                        rx_own_r;

  // a frame finishing while another still waits on a full fifo is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r       <= '0;
      hold_valid_r <= 1'b0;
    end else if (!rx_enable_bit) begin
      hold_valid_r <= 1'b0;
    end else if (frame_done && (!hold_valid_r || fifo_in_ready)) begin
      hold_r       <= {rx_pe, rx_fe, rx_aligned};
      hold_valid_r <= 1'b1;
    end else if (fifo_in_ready) begin
      hold_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dor_pend_r <= 1'b0;
    end else if (!rx_enable_bit) begin
      dor_pend_r <= 1'b0;
    end else if (start_det && hold_valid_r && !fifo_in_ready) begin
      dor_pend_r <= 1'b1;
    end else if (hold_valid_r && fifo_in_ready) begin
      dor_pend_r <= 1'b0;
    end
  end

  utrb_fifo #(
    .W (utrb_pkg::WORD_W),
    .D (RX_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .flush     (~rx_enable_bit),
    .in_valid  (hold_valid_r),
    .in_ready  (fifo_in_ready),
    .in_data   ({dor_pend_r, hold_r}),
    .out_valid (fifo_out_valid),
    .out_ready (data_rd),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_own_r <= 1'b0;
    end else begin
      rx_own_r <= rx_enable_bit;
    end
  end

  // flags are read only; they follow the head entry and move on with a data read
  assign rx_avail_flag    = fifo_out_valid;
  assign data_rdata       = fifo_out_data[7:0];
  assign rx_ninth_bit     = fifo_out_data[utrb_pkg::F_NINTH];
  assign stop_bit_error   = fifo_out_valid & fifo_out_data[utrb_pkg::F_FE];
  assign parity_fail_flag = fifo_out_valid & fifo_out_data[utrb_pkg::F_PE];
  assign overrun_flag     = fifo_out_valid & fifo_out_data[utrb_pkg::F_DOR];
  assign serial_in_owned  = rx_own_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests: levels, none from the error flags

  assign tx_empty_irq = global_irq_en & tx_empty_irq_en & ~txbuf_full_r;
  assign tx_done_irq  = global_irq_en & tx_done_irq_en & tx_done_r;
  assign rx_avail_irq = global_irq_en & rx_avail_irq_en & fifo_out_valid;

endmodule

// *** src/utrb_pkg.sv ***
// shared constants and state types for the serial transmit/receive buffer block
package utrb_pkg;

  // core clock and default line rate
  localparam int CLK_HZ   = 20_000_000;
  localparam int BAUD_HZ  = 9600;
  localparam int OS_RATE  = 16;
  localparam int BAUD_DIV = CLK_HZ / (BAUD_HZ * OS_RATE);
  localparam int DIV_W    = 16;

  // oversample positions: mid start bit and last tick of a bit
  localparam logic [3:0] OS_MID  = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_ZERO = 4'h0;

  // character size codes and bit counts
  localparam logic [2:0] CSZ_NINE    = 3'h7;
  localparam logic [2:0] CSZ_EIGHT   = 3'h3;
  localparam logic [3:0] NBITS_BASE  = 4'h5;
  localparam logic [3:0] NBITS_EIGHT = 4'h8;
  localparam logic [3:0] NBITS_NINE  = 4'h9;

  // receive word layout: data, ninth bit, then the per-frame flags
  localparam int DATA_W  = 9;
  localparam int HOLD_W  = 11;
  localparam int WORD_W  = 12;
  localparam int F_NINTH = 8;
  localparam int F_FE    = 9;
  localparam int F_PE    = 10;
  localparam int F_DOR   = 11;

  // buffer depths
  localparam int RX_DEPTH       = 2;
  localparam int FIFO_DEPTH_DEF = 16;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } utrb_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } utrb_rx_state_t;

endpackage

// *** src/utrb_baud.sv ***
// oversample rate divider: one-cycle enable pulse every DIV core clocks
`timescale 1ns/1ps
module utrb_baud #(
  parameter int DIV = utrb_pkg::BAUD_DIV
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      tick
);

  localparam logic [utrb_pkg::DIV_W-1:0] LAST = utrb_pkg::DIV_W'(DIV - 1);

  logic [utrb_pkg::DIV_W-1:0] cnt_r;
  logic                       tick_r;

  // counter held at zero while idle so the first pulse is a full period away
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (!en) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule

// *** src/utrb_fifo.sv ***
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module utrb_fifo #(
  parameter int W = utrb_pkg::WORD_W,
  parameter int D = utrb_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(D);
  localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < D; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // flush drops everything at once; pointers restart together
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

// *** verification/utrb_core_monitor.sv ***
// concurrent checks on the ports of the transmit/receive buffer block
`timescale 1ns/1ps
module utrb_core_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic data_wr,
  input wire logic tx_done_ack,
  input wire logic tx_done_clr,
  input wire logic tx_empty_irq_en,
  input wire logic tx_done_irq_en,
  input wire logic rx_avail_irq_en,
  input wire logic global_irq_en,
  input wire logic tx_buffer_empty_flag,
  input wire logic tx_done_flag,
  input wire logic rx_avail_flag,
  input wire logic stop_bit_error,
  input wire logic overrun_flag,
  input wire logic parity_fail_flag,
  input wire logic tx_empty_irq,
  input wire logic tx_done_irq,
  input wire logic rx_avail_irq,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wr; data_wr && tx_enable_bit |=> !tx_buffer_empty_flag; endproperty
  a_wr: assert property (p_wr) else $error("empty flag kept after write");
  property p_eirq; tx_empty_irq == (tx_buffer_empty_flag && tx_empty_irq_en && global_irq_en); endproperty
  a_eirq: assert property (p_eirq) else $error("empty request wrong");
  property p_dirq; $rose(tx_done_flag) && tx_done_irq_en && global_irq_en |-> tx_done_irq; endproperty
  a_dirq: assert property (p_dirq) else $error("done request missing");
  property p_dclr; (tx_done_ack || tx_done_clr) && tx_buffer_empty_flag |=> !tx_done_flag; endproperty
  a_dclr: assert property (p_dclr) else $error("done flag not cleared");
  property p_rirq; rx_avail_irq == (rx_avail_flag && rx_avail_irq_en && global_irq_en); endproperty
  a_rirq: assert property (p_rirq) else $error("receive request wrong");
  property p_off; !rx_enable_bit |=> !rx_avail_flag; endproperty
  a_off: assert property (p_off) else $error("fifo kept data while off");
  property p_err; !rx_avail_flag |-> !(stop_bit_error || overrun_flag || parity_fail_flag); endproperty
  a_err: assert property (p_err) else $error("error flag without frame");
  // a low bit means a frame is on the wire, so the pin must stay owned
  property p_own; serial_out_oe && !serial_out_pin |=> serial_out_oe; endproperty
  a_own: assert property (p_own) else $error("pin released mid frame");
endmodule
bind utrb_core utrb_core_monitor mon (.*);

// *** verification/utrb_peer.sv ***
// remote transceiver model: drives the receive line, samples the transmit line
`timescale 1ns/1ps
module utrb_peer (
  input  wire logic core_clk,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  initial serial_in_pin = 1'h1;
  // bit time fixed at 32 cycles, matching a divider of 2
  task automatic bit_out(input logic b);
    serial_in_pin <= b;
    repeat (32) @(posedge core_clk);
  endtask
  task automatic send(input logic [8:0] d, input int n, input logic [1:0] ps, input logic stp);
    bit_out(1'h0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (ps[1]) bit_out(ps[0]);
    bit_out(stp);
    bit_out(1'h1);
  endtask
  task automatic grab(input int k, output logic [11:0] w);
    w = 12'h000;
    @(negedge serial_out_pin);
    repeat (16) @(posedge core_clk);
    for (int i = 0; i < k; i++) begin
      w[i] = serial_out_pin;
      repeat (32) @(posedge core_clk);
    end
  endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the serial transmit/receive buffer block
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst_n = 0, sync_mode = 0, sync_clock_pin = 0, stop_count_select = 0;
  logic tx_enable_bit, rx_enable_bit, parity_enable_bit, parity_odd_select, data_wr, data_rd;
  logic tx_empty_irq_en, tx_done_irq_en, rx_avail_irq_en, global_irq_en, tx_done_clr, tx_done_ack;
  logic tx_ninth_bit, serial_in_pin, tx_buffer_empty_flag, tx_done_flag, rx_avail_flag;
  logic stop_bit_error, overrun_flag, parity_fail_flag, tx_empty_irq, tx_done_irq, rx_avail_irq;
  logic serial_out_pin, serial_out_oe, serial_in_owned, rx_ninth_bit;
  logic [2:0] char_size_code;
  logic [7:0] data_wdata, data_rdata;
  logic [11:0] w;
  int mismatches = 0, n_compared = 0, cyc = 0;
  utrb_core #(.BAUD_DIV(2)) DUT (.*);
  utrb_peer peer (.*);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 20000) begin mismatches++; report_and_stop(); end
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    data_wdata = d; data_wr = 1; tick(); data_wr = 0;
  endtask
  // flags and ninth bit are looked at before the pop moves the head
  task automatic rd(input logic [11:0] exp);
    chk({overrun_flag, parity_fail_flag, stop_bit_error, rx_ninth_bit, data_rdata}, exp);
    data_rd = 1; tick(); data_rd = 0; tick();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {tx_enable_bit, rx_enable_bit, parity_enable_bit, parity_odd_select, data_wr, data_rd} = '0;
    {tx_empty_irq_en, tx_done_irq_en, rx_avail_irq_en, global_irq_en, tx_done_clr, tx_done_ack} = '0;
    tx_ninth_bit = 0; char_size_code = 3'h3; data_wdata = 8'h00;
    tick(5); rst_n = 1; tick();
    chk({tx_buffer_empty_flag, tx_done_flag, rx_avail_flag, stop_bit_error, overrun_flag, parity_fail_flag}, 12'h020);
    {tx_enable_bit, rx_enable_bit, parity_enable_bit, global_irq_en, tx_done_irq_en, tx_empty_irq_en} = '1;
    rx_avail_irq_en = 1; tick();
    chk({tx_empty_irq, serial_in_owned}, 12'h003);
    for (int k = 0; k < 2; k++) begin
      parity_odd_select = k[0];
      char_size_code = k ? 3'h7 : 3'h3;
      tx_ninth_bit = k[0];
      fork
        begin wr(k ? 8'ha7 : 8'ha5); chk(tx_buffer_empty_flag, 12'h000); tx_enable_bit = (k == 0); end
        peer.grab(11 + k, w);
      join
      chk(w, k ? {1'h1, ~^9'h1a7, 9'h1a7, 1'h0} : {1'h0, 1'h1, ^8'ha5, 8'ha5, 1'h0});
      tick();
      chk({tx_done_flag, tx_done_irq}, 12'h003);
      {tx_done_clr, tx_done_ack} = k ? 2'h2 : 2'h1; tick(); {tx_done_clr, tx_done_ack} = 2'h0;
      chk(tx_done_flag, 12'h000);
      tick(2);
      chk(serial_out_oe, k == 0);
      tx_enable_bit = 1;
    end
    $display("test transmit done");
    char_size_code = 3'h0; parity_odd_select = 1;
    peer.send(9'h01b, 5, 2'h3, 1'h1);
    peer.send(9'h00e, 5, 2'h3, 1'h0);
    peer.send(9'h015, 5, 2'h2, 1'h1);
    peer.send(9'h01b, 5, 2'h3, 1'h1);
    tick(4);
    chk(rx_avail_irq, 12'h001);
    rd(12'h01b);
    rd(12'h60e);
    rd(12'h815);
    chk(rx_avail_flag, 12'h000);
    $display("test receive errors done");
    char_size_code = 3'h7; parity_enable_bit = 0;
    peer.send(9'h1c3, 9, 2'h0, 1'h1);
    tick(4);
    chk({parity_fail_flag, rx_ninth_bit, data_rdata}, 12'h1c3);
    rx_enable_bit = 0; tick();
    chk({rx_avail_flag, serial_in_owned}, 12'h000);
    $display("test nine bit and flush done");
    report_and_stop();
  end
endmodule
